// *** verilog/core_registers.v ***
// programmer-visible register file, stack sequencer and vector fetch of the 8-bit core
// Summary of operation
// - separate read-only program, read/write data spaces
// - sixteen-bit program counter from two byte halves
// - reset loads counter from vector at FFFE/FFFF
// - accumulator alone or paired under index Y
// - index adds to address; inc, dec, compare
// - eight-bit stack pointer, page one, not reset
// - decrement after save, increment before restore
// - interrupt return restores flags; subroutine return not
// - carry from arithmetic, shifts and rotates
// - zero flag follows result of arithmetic, transfers
// - interrupt enable gates all but reset, break
// - enable/disable instructions; cleared when interrupt served
// - half carry from bit three; cleared by clear-overflow
// - break sets break flag, shares table vector
// - page flag picks direct page zero or one
// - signed overflow flag; arithmetic and bit-test set or clear it, clear-overflow clears it
// - negative follows bit seven; bit-test copies bits
// - program addresses wrap past FFFF to 0000
// - interrupt vectors descend in two-byte slots
// - table call fifteen at FFC0, ascending downward
// - page call reaches page FF subroutine area
// - unused vector locations are ordinary program memory
`include "core_regs_defines.vh"
`default_nettype none

module core_registers (
	// clock and reset
	input wire core_clk,
	input wire reset_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// operation port
	input wire op_valid,
	input wire [5:0] op_code,
	input wire [7:0] op_data,
	input wire [15:0] op_addr,
	output reg busy,
	// interrupt request
	input wire irq_req,
	input wire [3:0] irq_src,
	output reg irq_ack,
	// program memory, read only
	output reg [15:0] prog_addr,
	output reg prog_rd,
	input wire [7:0] prog_rdata,
	// data memory
	output reg [8:0] data_addr,
	output reg [7:0] data_wdata,
	output reg data_wr,
	output reg data_rd,
	input wire [7:0] data_rdata,
	// effective data address
	output reg [15:0] eff_addr
);

	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_PUSH = 4'h1;
	localparam [3:0] S_VLO = 4'h2;
	localparam [3:0] S_VHI = 4'h3;
	localparam [3:0] S_VW1 = 4'h4;
	localparam [3:0] S_VW2 = 4'h5;
	localparam [3:0] S_POPI = 4'h6;
	localparam [3:0] S_POPW = 4'h7;
	localparam [3:0] S_POPT = 4'h8;

	reg [7:0] pc_high_byte_reg;
	reg [7:0] pc_low_byte_reg;
	reg [7:0] acc_reg;
	reg [7:0] x_reg;
	reg [7:0] y_reg;
	reg [7:0] stack_pointer_reg;
	reg [7:0] stack_pointer_next;
	reg [7:0] status_word_reg;
	reg [3:0] state_reg;
	reg [1:0] step_reg;
	reg [15:0] vec_reg;
	reg [15:0] target_reg;
	reg [7:0] tmp_reg;
	reg save_psw_reg;
	reg use_vec_reg;

	reg [4:0] sum_lo;
	reg [8:0] sum9;
	reg [4:0] dif_lo;
	reg [8:0] dif9;
	reg [7:0] sh_res;
	reg sh_c;
	reg [8:0] cmp9;

	wire [15:0] pc16;
	wire [15:0] paired_word;
	wire c_flag;
	wire take_irq;
	wire take_op;
	wire [7:0] sp_inc;

	assign pc16 = {pc_high_byte_reg, pc_low_byte_reg};
	assign paired_word = {y_reg, acc_reg};
	assign c_flag = status_word_reg[`BIT_C];
	assign take_irq = (state_reg == S_IDLE) && irq_req && status_word_reg[`BIT_I];
	assign take_op = (state_reg == S_IDLE) && op_valid && !take_irq;
	assign sp_inc = stack_pointer_reg + 8'h01;

	// refresh N and Z from a result
	function [7:0] with_nz;
		input [7:0] status_word;
		input [7:0] res;
		begin
			with_nz = status_word;
			with_nz[`BIT_N] = res[7];
			with_nz[`BIT_Z] = (res == 8'h00);
		end
	endfunction

	// vector of table call n: call 15 lowest, each lower number one slot up
	function [15:0] table_call_vec;
		input [3:0] n;
		begin
			table_call_vec = `VEC_TCALL15 + {11'h000, ~n, 1'b0};
		end
	endfunction

	// arithmetic and shifter
	always @* begin
		sum_lo = {1'b0, acc_reg[3:0]} + {1'b0, op_data[3:0]} + {4'h0, c_flag};
		sum9 = {1'b0, acc_reg} + {1'b0, op_data} + {8'h00, c_flag};
		dif_lo = {1'b0, acc_reg[3:0]} - {1'b0, op_data[3:0]} - {4'h0, ~c_flag};
		dif9 = {1'b0, acc_reg} - {1'b0, op_data} - {8'h00, ~c_flag};
		cmp9 = (op_code == `OP_CMPY) ? ({1'b0, y_reg} - {1'b0, op_data}) : ({1'b0, x_reg} - {1'b0, op_data});
		case (op_code)
			`OP_ASL: begin
				sh_res = {acc_reg[6:0], 1'b0};
				sh_c = acc_reg[7];
			end
			`OP_ROL: begin
				sh_res = {acc_reg[6:0], c_flag};
				sh_c = acc_reg[7];
			end
			`OP_LSR: begin
				sh_res = {1'b0, acc_reg[7:1]};
				sh_c = acc_reg[0];
			end
			default: begin
				sh_res = {c_flag, acc_reg[7:1]};
				sh_c = acc_reg[0];
			end
		endcase
	end

	// stack pointer has no reset: software must load it before first use
	always @* begin
		stack_pointer_next = stack_pointer_reg;
		if (state_reg == S_PUSH) begin
			stack_pointer_next = stack_pointer_reg - 8'h01;
		end else if (state_reg == S_POPI) begin
			stack_pointer_next = sp_inc;
		end else if (take_op && op_code == `OP_LDSP) begin
			stack_pointer_next = op_data;
		end else if (reg_wr && reg_addr == `OFF_SP) begin
			stack_pointer_next = reg_wdata;
		end
	end

	always @(posedge core_clk) begin
		stack_pointer_reg <= stack_pointer_next;
	end

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_high_byte_reg <= `DATA_RESET;
			pc_low_byte_reg <= `DATA_RESET;
			acc_reg <= `DATA_RESET;
			x_reg <= `DATA_RESET;
			y_reg <= `DATA_RESET;
			status_word_reg <= `STATUS_RESET;
			state_reg <= S_VLO;
			step_reg <= 2'b00;
			vec_reg <= `VEC_RESET;
			target_reg <= `ADDR_RESET;
			tmp_reg <= `DATA_RESET;
			save_psw_reg <= 1'b0;
			use_vec_reg <= 1'b1;
			reg_rdata <= `DATA_RESET;
			busy <= 1'b1;
			irq_ack <= 1'b0;
			prog_addr <= `ADDR_RESET;
			prog_rd <= 1'b0;
			data_addr <= 9'h000;
			data_wdata <= `DATA_RESET;
			data_wr <= 1'b0;
			data_rd <= 1'b0;
			eff_addr <= `ADDR_RESET;
		end else begin
			prog_rd <= 1'b0;
			data_wr <= 1'b0;
			data_rd <= 1'b0;
			irq_ack <= 1'b0;
			reg_rdata <= `DATA_RESET;
			if (reg_rd) begin
				case (reg_addr)
					`OFF_PC_LOW: reg_rdata <= pc_low_byte_reg;
					`OFF_PC_HIGH: reg_rdata <= pc_high_byte_reg;
					`OFF_ACC: reg_rdata <= paired_word[7:0];
					`OFF_IDX_X: reg_rdata <= x_reg;
					`OFF_IDX_Y: reg_rdata <= paired_word[15:8];
					`OFF_SP: reg_rdata <= stack_pointer_reg;
					`OFF_STATUS: reg_rdata <= status_word_reg;
					`OFF_EA_LOW: reg_rdata <= eff_addr[7:0];
					`OFF_EA_HIGH: reg_rdata <= eff_addr[15:8];
					`OFF_CORE_STATE: reg_rdata <= {4'h0, state_reg};
					default: reg_rdata <= `DATA_RESET;
				endcase
			end
			// port writes come first so a same-cycle operation overrides them
			if (reg_wr) begin
				case (reg_addr)
					`OFF_PC_LOW: pc_low_byte_reg <= reg_wdata;
					`OFF_PC_HIGH: pc_high_byte_reg <= reg_wdata;
					`OFF_ACC: acc_reg <= reg_wdata;
					`OFF_IDX_X: x_reg <= reg_wdata;
					`OFF_IDX_Y: y_reg <= reg_wdata;
					`OFF_STATUS: status_word_reg <= reg_wdata;
					default: begin
					end
				endcase
			end
			case (state_reg)
				S_IDLE: begin
					if (take_irq) begin
						// served interrupt: flags saved as they were, then enable cleared
						tmp_reg <= status_word_reg;
						status_word_reg[`BIT_I] <= 1'b0;
						vec_reg <= `VEC_EXT0 - {11'h000, irq_src, 1'b0};
						save_psw_reg <= 1'b1;
						use_vec_reg <= 1'b1;
						step_reg <= 2'b00;
						irq_ack <= 1'b1;
						busy <= 1'b1;
						state_reg <= S_PUSH;
					end else if (take_op) begin
						case (op_code)
							`OP_LDA: begin
								acc_reg <= op_data;
								status_word_reg <= with_nz(status_word_reg, op_data);
							end
							`OP_LDX: begin
								x_reg <= op_data;
								status_word_reg <= with_nz(status_word_reg, op_data);
							end
							`OP_LDY: begin
								y_reg <= op_data;
								status_word_reg <= with_nz(status_word_reg, op_data);
							end
							`OP_LDYA: begin
								{y_reg, acc_reg} <= op_addr;
								status_word_reg[`BIT_N] <= op_addr[15];
								status_word_reg[`BIT_Z] <= (op_addr == 16'h0000);
							end
							`OP_ADC: begin
								acc_reg <= sum9[7:0];
								status_word_reg <= {sum9[7], (acc_reg[7] == op_data[7]) && (sum9[7] != acc_reg[7]),
									status_word_reg[5:4], sum_lo[4], status_word_reg[2], sum9[7:0] == 8'h00,
									sum9[8]};
							end
							`OP_SBC: begin
								acc_reg <= dif9[7:0];
								status_word_reg <= {dif9[7], (acc_reg[7] != op_data[7]) && (dif9[7] != acc_reg[7]),
									status_word_reg[5:4], ~dif_lo[4], status_word_reg[2], dif9[7:0] == 8'h00,
									~dif9[8]};
							end
							`OP_ASL, `OP_ROL, `OP_LSR, `OP_ROR: begin
								acc_reg <= sh_res;
								status_word_reg <= with_nz({status_word_reg[7:1], sh_c}, sh_res);
							end
							`OP_INX: begin
								x_reg <= x_reg + 8'h01;
								status_word_reg <= with_nz(status_word_reg, x_reg + 8'h01);
							end
							`OP_DEX: begin
								x_reg <= x_reg - 8'h01;
								status_word_reg <= with_nz(status_word_reg, x_reg - 8'h01);
							end
							`OP_INY: begin
								y_reg <= y_reg + 8'h01;
								status_word_reg <= with_nz(status_word_reg, y_reg + 8'h01);
							end
							`OP_DEY: begin
								y_reg <= y_reg - 8'h01;
								status_word_reg <= with_nz(status_word_reg, y_reg - 8'h01);
							end
							`OP_CMPX, `OP_CMPY: begin
								status_word_reg <= with_nz({status_word_reg[7:1], ~cmp9[8]}, cmp9[7:0]);
							end
							`OP_BIT: begin
								status_word_reg[`BIT_N] <= op_data[7];
								status_word_reg[`BIT_V] <= op_data[6];
								status_word_reg[`BIT_Z] <= ((acc_reg & op_data) == 8'h00);
							end
							`OP_EI: status_word_reg[`BIT_I] <= 1'b1;
							`OP_DI: status_word_reg[`BIT_I] <= 1'b0;
							`OP_CLEAR_OVERFLOW_INSTR: begin
								status_word_reg[`BIT_V] <= 1'b0;
								status_word_reg[`BIT_H] <= 1'b0;
							end
							`OP_SET_PAGE_FLAG_INSTR: status_word_reg[`BIT_G] <= 1'b1;
							`OP_CLEAR_PAGE_FLAG_INSTR: status_word_reg[`BIT_G] <= 1'b0;
							`OP_IDXX: eff_addr <= op_addr + {8'h00, x_reg};
							`OP_IDXY: eff_addr <= op_addr + {8'h00, y_reg};
							`OP_DIRECT: eff_addr <= {7'h00, status_word_reg[`BIT_G], op_data};
							`OP_PCADV: {pc_high_byte_reg, pc_low_byte_reg} <= pc16 + {8'h00, op_data};
							`OP_JUMP: {pc_high_byte_reg, pc_low_byte_reg} <= op_addr;
							`OP_CALL, `OP_PAGE_CALL: begin
								target_reg <= (op_code == `OP_PAGE_CALL) ? {`PAGE_CALL_PAGE, op_data} : op_addr;
								save_psw_reg <= 1'b0;
								use_vec_reg <= 1'b0;
								step_reg <= 2'b00;
								busy <= 1'b1;
								state_reg <= S_PUSH;
							end
							`OP_TABLE_CALL: begin
								vec_reg <= table_call_vec(op_data[3:0]);
								save_psw_reg <= 1'b0;
								use_vec_reg <= 1'b1;
								step_reg <= 2'b00;
								busy <= 1'b1;
								state_reg <= S_PUSH;
							end
							`OP_BRK: begin
								// not gated by the enable flag; shares table call 0 slot
								status_word_reg[`BIT_B] <= 1'b1;
								tmp_reg <= status_word_reg | 8'h10;
								vec_reg <= table_call_vec(4'h0);
								save_psw_reg <= 1'b1;
								use_vec_reg <= 1'b1;
								step_reg <= 2'b00;
								busy <= 1'b1;
								state_reg <= S_PUSH;
							end
							`OP_RET, `OP_INTERRUPT_RETURN: begin
								// only the interrupt return takes the flag byte back
								step_reg <= (op_code == `OP_INTERRUPT_RETURN) ? 2'b00 : 2'b01;
								busy <= 1'b1;
								state_reg <= S_POPI;
							end
							default: begin
							end
						endcase
					end
				end
				S_PUSH: begin
					// save order: counter high, counter low, then flags if any
					data_wr <= 1'b1;
					data_addr <= {`STACK_PAGE, stack_pointer_reg};
					if (step_reg == 2'b00) begin
						data_wdata <= pc_high_byte_reg;
					end else if (step_reg == 2'b01) begin
						data_wdata <= pc_low_byte_reg;
					end else begin
						data_wdata <= tmp_reg;
					end
					if (step_reg == 2'b10 || (step_reg == 2'b01 && !save_psw_reg)) begin
						if (use_vec_reg) begin
							state_reg <= S_VLO;
						end else begin
							{pc_high_byte_reg, pc_low_byte_reg} <= target_reg;
							busy <= 1'b0;
							state_reg <= S_IDLE;
						end
					end else begin
						step_reg <= step_reg + 2'b01;
					end
				end
				S_VLO: begin
					// vector slots are plain program reads; nothing in FF00-FFFF is reserved
					prog_addr <= vec_reg;
					prog_rd <= 1'b1;
					state_reg <= S_VHI;
				end
				S_VHI: begin
					prog_addr <= vec_reg + 16'h0001;
					prog_rd <= 1'b1;
					state_reg <= S_VW1;
				end
				S_VW1: begin
					tmp_reg <= prog_rdata;
					state_reg <= S_VW2;
				end
				S_VW2: begin
					{pc_high_byte_reg, pc_low_byte_reg} <= {prog_rdata, tmp_reg};
					busy <= 1'b0;
					state_reg <= S_IDLE;
				end
				S_POPI: begin
					data_addr <= {`STACK_PAGE, sp_inc};
					data_rd <= 1'b1;
					state_reg <= S_POPW;
				end
				S_POPW: begin
					state_reg <= S_POPT;
				end
				S_POPT: begin
					if (step_reg == 2'b00) begin
						status_word_reg <= data_rdata;
					end else if (step_reg == 2'b01) begin
						tmp_reg <= data_rdata;
					end else begin
						{pc_high_byte_reg, pc_low_byte_reg} <= {data_rdata, tmp_reg};
					end
					if (step_reg == 2'b10) begin
						busy <= 1'b0;
						state_reg <= S_IDLE;
					end else begin
						step_reg <= step_reg + 2'b01;
						state_reg <= S_POPI;
					end
				end
				default: begin
					busy <= 1'b0;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// *** verilog/core_regs_defines.vh ***
// constants shared by the core register file: offsets, flag bits, vectors, operations
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH
// register port offsets
`define OFF_PC_LOW 4'h0
`define OFF_PC_HIGH 4'h1
`define OFF_ACC 4'h2
`define OFF_IDX_X 4'h3
`define OFF_IDX_Y 4'h4
`define OFF_SP 4'h5
`define OFF_STATUS 4'h6
`define OFF_EA_LOW 4'h7
`define OFF_EA_HIGH 4'h8
`define OFF_CORE_STATE 4'h9
// status word bit positions
`define BIT_N 7
`define BIT_V 6
`define BIT_G 5
`define BIT_B 4
`define BIT_H 3
`define BIT_I 2
`define BIT_Z 1
`define BIT_C 0
// reset values
`define STATUS_RESET 8'h00
`define DATA_RESET 8'h00
`define ADDR_RESET 16'h0000
// program memory map
`define VEC_RESET 16'hFFFE
`define VEC_EXT0 16'hFFFA
`define VEC_TCALL15 16'hFFC0
`define PAGE_CALL_PAGE 8'hFF
// stack sits in the second data page
`define STACK_PAGE 1'b1
// operation codes
`define OP_NOP 6'h00
`define OP_LDA 6'h01
`define OP_LDX 6'h02
`define OP_LDY 6'h03
`define OP_LDSP 6'h04
`define OP_ADC 6'h05
`define OP_SBC 6'h06
`define OP_ASL 6'h07
`define OP_ROL 6'h08
`define OP_LSR 6'h09
`define OP_ROR 6'h0A
`define OP_INX 6'h0B
`define OP_DEX 6'h0C
`define OP_INY 6'h0D
`define OP_DEY 6'h0E
`define OP_CMPX 6'h0F
`define OP_CMPY 6'h10
`define OP_BIT 6'h11
`define OP_EI 6'h12
`define OP_DI 6'h13
`define OP_CLEAR_OVERFLOW_INSTR 6'h14
`define OP_SET_PAGE_FLAG_INSTR 6'h15
`define OP_CLEAR_PAGE_FLAG_INSTR 6'h16
`define OP_IDXX 6'h17
`define OP_IDXY 6'h18
`define OP_DIRECT 6'h19
`define OP_PCADV 6'h1A
`define OP_CALL 6'h1B
`define OP_PAGE_CALL 6'h1C
`define OP_TABLE_CALL 6'h1D
`define OP_BRK 6'h1E
`define OP_RET 6'h1F
`define OP_INTERRUPT_RETURN 6'h20
`define OP_JUMP 6'h21
`define OP_LDYA 6'h22
`endif

// *** verif/mem_model.sv ***
// program memory pattern and data memory array seen by the core
`default_nettype none
module mem_model (
	// clock
	input wire logic core_clk,
	// program side
	input wire logic [15:0] prog_addr,
	input wire logic prog_rd,
	output logic [7:0] prog_rdata,
	// data side
	input wire logic [8:0] data_addr,
	input wire logic [7:0] data_wdata,
	input wire logic data_wr,
	input wire logic data_rd,
	output logic [7:0] data_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] data_mem [0:511];
	initial begin
		prog_rdata = 8'h00;
		data_rdata = 8'h00;
	end
	// idle read lines flip every cycle so a late sample never looks valid
	always @(posedge core_clk) begin
		prog_rdata <= prog_rd ? (prog_addr[7:0] ^ 8'hA5) : ~prog_rdata;
		data_rdata <= data_rd ? data_mem[data_addr] : ~data_rdata;
		if (data_wr) begin
			data_mem[data_addr] <= data_wdata;
		end
	end
endmodule
`default_nettype wire

// *** verif/core_registers_chk.sv ***
// port assertions for the core register file
`include "core_regs_defines.vh"
`default_nettype none
module core_registers_chk (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// operation and interrupt
	input wire logic op_valid,
	input wire logic [5:0] op_code,
	input wire logic busy,
	input wire logic irq_req,
	input wire logic [3:0] irq_src,
	input wire logic irq_ack,
	// memories
	input wire logic [15:0] prog_addr,
	input wire logic prog_rd,
	input wire logic [8:0] data_addr,
	input wire logic data_wr,
	input wire logic data_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence call_taken;
		op_valid && op_code == `OP_CALL && !busy && !irq_req;
	endsequence
	sequence ret_taken;
		op_valid && (op_code == `OP_RET || op_code == `OP_INTERRUPT_RETURN) && !busy && !irq_req;
	endsequence
	sequence push_two;
		(data_wr && busy) ##1 (data_wr && !busy);
	endsequence
	a_call_pushes: assert property (call_taken |=> ##1 push_two)
		else $error("call push sequence wrong");
	a_ret_pops: assert property (ret_taken |=> ##[0:4] (data_rd && data_addr[8]))
		else $error("return did not pop the stack page");
	a_vector_pair: assert property (prog_rd && prog_addr == 16'hFFFE |=> prog_rd && prog_addr == 16'hFFFF)
		else $error("reset vector high byte not fetched");
	a_stack_page: assert property (data_wr |-> data_addr[8])
		else $error("stack write outside page one");
	a_strobes_apart: assert property (!(data_wr && data_rd))
		else $error("save and restore at once");
	a_irq_vector: assert property (irq_ack |-> ##[1:12] (prog_rd && prog_addr == 16'hFFFA - {11'h000, irq_src, 1'b0}))
		else $error("wrong interrupt vector");
	a_ack_cause: assert property (irq_ack |-> $past(irq_req) && !$past(busy))
		else $error("interrupt taken without request");
	a_ack_single: assert property (irq_ack |=> !irq_ack)
		else $error("interrupt taken twice");
endmodule
bind core_registers core_registers_chk chk_i (
	.core_clk(core_clk),
	.reset_n(reset_n),
	.op_valid(op_valid),
	.op_code(op_code),
	.busy(busy),
	.irq_req(irq_req),
	.irq_src(irq_src),
	.irq_ack(irq_ack),
	.prog_addr(prog_addr),
	.prog_rd(prog_rd),
	.data_addr(data_addr),
	.data_wr(data_wr),
	.data_rd(data_rd)
);
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the core register file
`include "core_regs_defines.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0, irq_req = 1'b0;
	logic [3:0] reg_addr = 4'h0, irq_src = 4'h0;
	logic [7:0] reg_wdata = 8'h00, op_data = 8'h00;
	logic [5:0] op_code = 6'h00;
	logic [15:0] op_addr = 16'h0000;
	logic [7:0] reg_rdata, prog_rdata, data_wdata, data_rdata;
	logic busy, irq_ack, prog_rd, data_wr, data_rd, seen;
	logic [15:0] prog_addr, eff_addr;
	logic [8:0] data_addr;
	logic [5:0] fl_op [4] = '{`OP_SET_PAGE_FLAG_INSTR, `OP_CLEAR_PAGE_FLAG_INSTR, `OP_EI, `OP_DI};
	logic [7:0] fl_exp [4] = '{8'h23, 8'h03, 8'h07, 8'h03};
	int err_count = 0, checks = 0, cycles = 0;
	core_registers uut (
		.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_valid(op_valid), .op_code(op_code), .op_data(op_data), .op_addr(op_addr), .busy(busy),
		.irq_req(irq_req), .irq_src(irq_src), .irq_ack(irq_ack),
		.prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
		.data_addr(data_addr), .data_wdata(data_wdata), .data_wr(data_wr), .data_rd(data_rd),
		.data_rdata(data_rdata), .eff_addr(eff_addr)
	);
	mem_model mem_i (
		.core_clk(core_clk), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
		.data_addr(data_addr), .data_wdata(data_wdata), .data_wr(data_wr), .data_rd(data_rd),
		.data_rdata(data_rdata)
	);
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic test_done();
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk8({7'h00, busy}, 8'h00);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask
	task automatic pc_chk(input logic [15:0] exp);
		rchk(`OFF_PC_LOW, exp[7:0]);
		rchk(`OFF_PC_HIGH, exp[15:8]);
	endtask
	task automatic op(input logic [5:0] c, input logic [7:0] d, input logic [15:0] a);
		@(posedge core_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_data <= d;
		op_addr <= a;
		@(posedge core_clk);
		op_valid <= 1'b0;
		#1;
		wait_idle();
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		#1;
		wait_idle();
		// program byte at address a is a[7:0]^A5, so vectors are known words
		pc_chk(16'h5A5B);
		rchk(`OFF_STATUS, 8'h00);
		op(`OP_LDA, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h02);
		op(`OP_LDA, 8'h80, 16'h0000);
		rchk(`OFF_STATUS, 8'h80);
		op(`OP_LDA, 8'h7F, 16'h0000);
		op(`OP_ADC, 8'h01, 16'h0000);
		rchk(`OFF_ACC, 8'h80);
		rchk(`OFF_STATUS, 8'hC8);
		op(`OP_CLEAR_OVERFLOW_INSTR, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h80);
		op(`OP_ASL, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h03);
		for (int i = 0; i < 4; i++) begin
			op(fl_op[i], 8'h00, 16'h0000);
			rchk(`OFF_STATUS, fl_exp[i]);
		end
		wr(`OFF_IDX_X, 8'h10);
		wr(`OFF_IDX_Y, 8'h12);
		wr(`OFF_ACC, 8'h34);
		rchk(`OFF_IDX_Y, 8'h12);
		rchk(`OFF_ACC, 8'h34);
		rchk(4'hF, 8'h00);
		op(`OP_IDXX, 8'h00, 16'h1234);
		chk16(eff_addr, 16'h1244);
		op(`OP_IDXY, 8'h00, 16'h1234);
		chk16(eff_addr, 16'h1246);
		op(`OP_INX, 8'h00, 16'h0000);
		rchk(`OFF_IDX_X, 8'h11);
		op(`OP_LDA, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h03);
		// stack starts below the top byte, which this test leaves unused
		wr(`OFF_SP, 8'hFE);
		wr(`OFF_PC_LOW, 8'h34);
		wr(`OFF_PC_HIGH, 8'h12);
		op(`OP_CALL, 8'h00, 16'h2000);
		pc_chk(16'h2000);
		rchk(`OFF_SP, 8'hFC);
		chk8(mem_i.data_mem[9'h1FE], 8'h12);
		chk8(mem_i.data_mem[9'h1FD], 8'h34);
		op(`OP_RET, 8'h00, 16'h0000);
		pc_chk(16'h1234);
		rchk(`OFF_SP, 8'hFE);
		op(`OP_EI, 8'h00, 16'h0000);
		@(posedge core_clk);
		irq_src <= 4'h2;
		irq_req <= 1'b1;
		for (int n = 0; n < 20 && irq_ack !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk8({7'h00, irq_ack}, 8'h01);
		@(posedge core_clk);
		irq_req <= 1'b0;
		#1;
		wait_idle();
		pc_chk(16'h5253);
		rchk(`OFF_STATUS, 8'h03);
		chk8(mem_i.data_mem[9'h1FC], 8'h07);
		op(`OP_INTERRUPT_RETURN, 8'h00, 16'h0000);
		pc_chk(16'h1234);
		rchk(`OFF_STATUS, 8'h07);
		op(`OP_DI, 8'h00, 16'h0000);
		seen = 1'b0;
		@(posedge core_clk);
		irq_req <= 1'b1;
		repeat (10) begin
			@(posedge core_clk);
			#1;
			seen = seen | irq_ack;
		end
		chk8({7'h00, seen}, 8'h00);
		@(posedge core_clk);
		irq_req <= 1'b0;
		op(`OP_BRK, 8'h00, 16'h0000);
		pc_chk(16'h7A7B);
		rchk(`OFF_STATUS, 8'h13);
		chk8(mem_i.data_mem[9'h1FC], 8'h13);
		op(`OP_LDYA, 8'h00, 16'h8001);
		rchk(`OFF_IDX_Y, 8'h80);
		rchk(`OFF_STATUS, 8'h91);
		op(`OP_SBC, 8'h02, 16'h0000);
		rchk(`OFF_ACC, 8'hFF);
		rchk(`OFF_STATUS, 8'h90);
		op(`OP_ROR, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h11);
		op(`OP_ROL, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h90);
		op(`OP_LSR, 8'h00, 16'h0000);
		rchk(`OFF_ACC, 8'h7F);
		rchk(`OFF_STATUS, 8'h11);
		op(`OP_CMPX, 8'h11, 16'h0000);
		rchk(`OFF_STATUS, 8'h13);
		op(`OP_CMPY, 8'h81, 16'h0000);
		rchk(`OFF_STATUS, 8'h90);
		op(`OP_BIT, 8'hC0, 16'h0000);
		rchk(`OFF_STATUS, 8'hD0);
		op(`OP_CLEAR_OVERFLOW_INSTR, 8'h00, 16'h0000);
		op(`OP_LDX, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h12);
		op(`OP_DEX, 8'h00, 16'h0000);
		rchk(`OFF_IDX_X, 8'hFF);
		op(`OP_LDY, 8'h7F, 16'h0000);
		op(`OP_INY, 8'h00, 16'h0000);
		rchk(`OFF_STATUS, 8'h90);
		op(`OP_DEY, 8'h00, 16'h0000);
		rchk(`OFF_IDX_Y, 8'h7F);
		op(`OP_SET_PAGE_FLAG_INSTR, 8'h00, 16'h0000);
		op(`OP_DIRECT, 8'h35, 16'h0000);
		rchk(`OFF_EA_HIGH, 8'h01);
		rchk(`OFF_EA_LOW, 8'h35);
		op(`OP_CLEAR_PAGE_FLAG_INSTR, 8'h00, 16'h0000);
		op(`OP_DIRECT, 8'h35, 16'h0000);
		chk16(eff_addr, 16'h0035);
		op(`OP_JUMP, 8'h00, 16'hFFFE);
		op(`OP_PCADV, 8'h03, 16'h0000);
		pc_chk(16'h0001);
		op(`OP_PAGE_CALL, 8'h35, 16'h0000);
		pc_chk(16'hFF35);
		rchk(`OFF_SP, 8'hF9);
		chk8(mem_i.data_mem[9'h1FA], 8'h01);
		op(`OP_TABLE_CALL, 8'h03, 16'h0000);
		pc_chk(16'h7C7D);
		op(`OP_LDSP, 8'hFE, 16'h0000);
		rchk(`OFF_SP, 8'hFE);
		rchk(`OFF_CORE_STATE, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
